// ===== hdl/hms_sequencer.sv
// homing method sequencer with ahb-lite register slave
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module hms_sequencer #(
  parameter int POS_W = 32
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              dog_input,
  input  wire logic              index_pulse,
  input  wire logic              forward_stroke_limit_input,
  input  wire logic              reverse_stroke_limit_input,
  input  wire logic              pos_step,
  input  wire logic              homing_operating_mode,
  output logic                   move_fwd,
  output logic                   move_rev,
  output logic                   homing_complete,
  output logic                   homing_incomplete_warning,
  output logic                   irq
);
  // two-flop synchronisers for the sensor, mode and step pins
  hms_pkg::hms_sense_t sense_m_q, sense_q, sense_p_q;
  logic [1:0] mode_sync_q;
  logic       step_m_q, step_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sense_m_q   <= '0;
      sense_q     <= '0;
      sense_p_q   <= '0;
      mode_sync_q <= '0;
      step_m_q    <= 1'b0;
      step_q      <= 1'b0;
    end else begin
      sense_m_q   <= '{dog_input, index_pulse, forward_stroke_limit_input, reverse_stroke_limit_input};
      sense_q     <= sense_m_q;
      sense_p_q   <= sense_q;
      mode_sync_q <= {mode_sync_q[0], homing_operating_mode};
      step_m_q    <= pos_step;
      step_q      <= step_m_q;
    end
  end
  logic dog_rise, index_rise;
  assign dog_rise   = sense_q.dog & ~sense_p_q.dog;
  assign index_rise = sense_q.index & ~sense_p_q.index;

  // bus state
  logic             wr_pend_q, wr_pend_d;
  logic [7:0]       wr_addr_q, wr_addr_d;
  logic             start_q, start_d, dirsel_q, dirsel_d;
  logic [7:0]       method_q, method_d;
  logic [POS_W-1:0] travel_q, travel_d, shift_q, shift_d;
  localparam int IRQ_W_L = hms_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_st_q, irq_st_d, mask_q, mask_d;
  logic [31:0]      hrdata_d, hrdata_q_r;
  // sequencer state
  hms_pkg::hms_state_t st_q, st_d;
  logic             dir_q, dir_d;    // 1 forward
  logic [POS_W-1:0] pos_q, pos_d, home_q, home_d, remain_q, remain_d;
  logic             done_q, done_d, warn_q, warn_d;
  logic             ev_done, ev_warn;

  // method decode: base (forward) code of a pair; method 1 is not a base
  function automatic logic is_base(input logic [7:0] m);
    is_base = (m == hms_pkg::M_CNT_FWD) || (m == hms_pkg::M_CRADLE_FWD) || (m == hms_pkg::M_LAST_FWD) ||
              (m == hms_pkg::M_FRONT_FWD) || (m == hms_pkg::M_DOGLESS_FWD);
  endfunction : is_base
  function automatic logic is_meth(input logic [7:0] m, input logic [7:0] base, input logic [7:0] pair);
    is_meth = (m == base) || (m == pair);
  endfunction : is_meth

  // register slave next values
  always_comb begin
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    start_d   = 1'b0;
    dirsel_d  = dirsel_q;
    method_d  = method_q;
    travel_d  = travel_q;
    shift_d   = shift_q;
    mask_d    = mask_q;
    irq_st_d  = irq_st_q;
    hrdata_d  = hrdata_q_r;
    if (wr_pend_q) begin
      case (wr_addr_q)
        hms_pkg::ADDR_CTRL: begin
          start_d  = hwdata[0];
          dirsel_d = hwdata[1];
        end
        hms_pkg::ADDR_METHOD: method_d = hwdata[7:0]; // RQ1
        hms_pkg::ADDR_TRAVEL: travel_d = hwdata[POS_W-1:0];
        hms_pkg::ADDR_SHIFT:  shift_d  = hwdata[POS_W-1:0];
        hms_pkg::ADDR_IRQ:    irq_st_d = irq_st_q & ~hwdata[IRQ_W_L-1:0];
        hms_pkg::ADDR_MASK:   mask_d   = hwdata[IRQ_W_L-1:0];
        default: ;
      endcase
    end
    irq_st_d = irq_st_d | {ev_warn, ev_done}; // set wins over clear
    if (hsel && hready && htrans[1]) begin
      wr_pend_d = hwrite;
      wr_addr_d = haddr;
      case (haddr)
        hms_pkg::ADDR_CTRL:   hrdata_d = {30'h0, dirsel_q, 1'b0};
        hms_pkg::ADDR_METHOD: hrdata_d = {24'h0, method_q};
        hms_pkg::ADDR_TRAVEL: hrdata_d = 32'(travel_q);
        hms_pkg::ADDR_SHIFT:  hrdata_d = 32'(shift_q);
        hms_pkg::ADDR_STATUS: hrdata_d = {24'h0, st_q, 1'b0, warn_q, done_q, (st_q != hms_pkg::HMS_IDLE)};
        hms_pkg::ADDR_HOME:   hrdata_d = 32'(home_q);
        hms_pkg::ADDR_POS:    hrdata_d = 32'(pos_q);
        hms_pkg::ADDR_IRQ:    hrdata_d = 32'(irq_st_q);
        hms_pkg::ADDR_MASK:   hrdata_d = 32'(mask_q);
        default:              hrdata_d = 32'h0; // unmapped reads zero
      endcase
    end
  end
  assign hrdata = hrdata_q_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= 8'h00;
      start_q    <= 1'b0;
      dirsel_q   <= 1'b0;
      method_q   <= hms_pkg::M_NEG_LIMIT;
      travel_q   <= '0;
      shift_q    <= '0;
      mask_q     <= '0;
      irq_st_q   <= '0;
      hrdata_q_r <= 32'h0;
      irq        <= 1'b0;
    end else begin
      wr_pend_q  <= wr_pend_d;
      wr_addr_q  <= wr_addr_d;
      start_q    <= start_d;
      dirsel_q   <= dirsel_d;
      method_q   <= method_d;
      travel_q   <= travel_d;
      shift_q    <= shift_d;
      mask_q     <= mask_d;
      irq_st_q   <= irq_st_d;
      hrdata_q_r <= hrdata_d;
      irq        <= |(irq_st_d & mask_d);
    end
  end
  assign hreadyout = 1'b1; // zero wait states
  assign hresp     = 1'b0; // always okay

  // sequencer next state
  always_comb begin
    st_d     = st_q;
    dir_d    = dir_q;
    pos_d    = pos_q;
    home_d   = home_q;
    remain_d = remain_q;
    done_d   = done_q;
    warn_d   = warn_q;
    ev_done  = 1'b0;
    ev_warn  = 1'b0;
    if (step_q) begin
      pos_d = dir_q ? pos_q + POS_W'(1) : pos_q - POS_W'(1);
    end
    case (st_q)
      hms_pkg::HMS_IDLE: begin
        if (start_q && mode_sync_q[1]) begin
          done_d = 1'b0; // RQ10
          warn_d = 1'b0;
          st_d   = hms_pkg::HMS_SEEK;
          if (method_q == hms_pkg::M_NEG_LIMIT) begin
            dir_d = dirsel_q; // RQ8
          end else begin
            dir_d = is_base(method_q) ^ dirsel_q; // RQ2
          end
        end
      end
      hms_pkg::HMS_SEEK: begin
        if (method_q == hms_pkg::M_NEG_LIMIT) begin
          if (dirsel_q ? sense_q.fwd_limit : sense_q.rev_limit) begin
            dir_d = ~dir_q; // RQ8
            st_d  = hms_pkg::HMS_LEAVE;
          end
        end else if (is_meth(method_q, hms_pkg::M_DOGLESS_FWD, hms_pkg::M_DOGLESS_REV)) begin
          if (index_rise) begin
            home_d = pos_q + shift_q; // RQ7
            st_d   = hms_pkg::HMS_DONE;
          end
        end else if (dog_rise) begin
          if (is_meth(method_q, hms_pkg::M_CNT_FWD, hms_pkg::M_CNT_REV) ||
              is_meth(method_q, hms_pkg::M_FRONT_FWD, hms_pkg::M_FRONT_REV)) begin
            remain_d = travel_q; // RQ3 RQ6
            st_d     = hms_pkg::HMS_OFFSET;
          end else if (is_meth(method_q, hms_pkg::M_LAST_FWD, hms_pkg::M_LAST_REV)) begin
            dir_d = ~dir_q; // RQ5
            st_d  = hms_pkg::HMS_INDEX;
          end else if (is_meth(method_q, hms_pkg::M_CRADLE_FWD, hms_pkg::M_CRADLE_REV)) begin
            st_d = hms_pkg::HMS_INDEX; // RQ4
          end else begin
            st_d = hms_pkg::HMS_ABORT; // unsupported code
          end
        end
      end
      hms_pkg::HMS_OFFSET: begin
        if (remain_q == '0) begin
          home_d = pos_q + shift_q; // RQ3 RQ6
          st_d   = hms_pkg::HMS_DONE;
        end else if (step_q) begin
          remain_d = remain_q - POS_W'(1);
        end
      end
      hms_pkg::HMS_LEAVE: begin
        if (!(dirsel_q ? sense_q.fwd_limit : sense_q.rev_limit)) begin
          st_d = hms_pkg::HMS_INDEX; // RQ8 left the stroke end
        end
      end
      hms_pkg::HMS_INDEX: begin
        if (method_q == hms_pkg::M_NEG_LIMIT &&
            (dirsel_q ? sense_q.rev_limit : sense_q.fwd_limit)) begin
          st_d = hms_pkg::HMS_ABORT; // RQ9
        end else if (index_rise) begin
          home_d = pos_q + shift_q; // RQ4 RQ5 RQ8
          st_d   = hms_pkg::HMS_DONE;
        end
      end
      hms_pkg::HMS_DONE: begin
        done_d  = 1'b1; // RQ10
        ev_done = 1'b1;
        st_d    = hms_pkg::HMS_IDLE;
      end
      hms_pkg::HMS_ABORT: begin
        warn_d  = 1'b1; // RQ9
        ev_warn = 1'b1;
        st_d    = hms_pkg::HMS_IDLE;
      end
      default: st_d = hms_pkg::HMS_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q     <= hms_pkg::HMS_IDLE;
      dir_q    <= 1'b1;
      pos_q    <= '0;
      home_q   <= '0;
      remain_q <= '0;
      done_q   <= 1'b0;
      warn_q   <= 1'b0;
      move_fwd <= 1'b0;
      move_rev <= 1'b0;
      homing_complete           <= 1'b0;
      homing_incomplete_warning <= 1'b0;
    end else begin
      st_q     <= st_d;
      dir_q    <= dir_d;
      pos_q    <= pos_d;
      home_q   <= home_d;
      remain_q <= remain_d;
      done_q   <= done_d;
      warn_q   <= warn_d;
      move_fwd <= (st_d inside {hms_pkg::HMS_SEEK, hms_pkg::HMS_OFFSET, hms_pkg::HMS_LEAVE, hms_pkg::HMS_INDEX}) & dir_d;
      move_rev <= (st_d inside {hms_pkg::HMS_SEEK, hms_pkg::HMS_OFFSET, hms_pkg::HMS_LEAVE, hms_pkg::HMS_INDEX}) & ~dir_d;
      homing_complete           <= done_d;
      homing_incomplete_warning <= warn_d;
    end
  end
endmodule : hms_sequencer

// ===== shared/hms_pkg.sv
// package for the homing method sequencer: register map, codes, types
// Summary of operation
// (RQ1) controller writes signed method code before start
// (RQ2) direction select swaps base and paired directions
// (RQ3) count type: dog edge, add travel and shift
// (RQ4) dog cradle: first index after dog edge
// (RQ5) last index: reverse off dog, first index
// (RQ6) dog front end: edge plus travel plus shift
// (RQ7) dogless: ignore dog, first index found
// (RQ8) negative limit: reverse to limit, index after
// (RQ9) forward limit before index aborts with warning
// (RQ10) complete flag cleared at start, set clean
package hms_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h00; // bit0 start (self clearing), bit1 direction select
  localparam logic [7:0] ADDR_METHOD  = 8'h04; // signed method code, low 8 bits
  localparam logic [7:0] ADDR_TRAVEL  = 8'h08; // travel distance after dog
  localparam logic [7:0] ADDR_SHIFT   = 8'h0c; // home position shift distance
  localparam logic [7:0] ADDR_STATUS  = 8'h10; // bit0 busy, bit1 complete, bit2 warning, bits7:4 state
  localparam logic [7:0] ADDR_HOME    = 8'h14; // latched home position
  localparam logic [7:0] ADDR_POS     = 8'h18; // live position
  localparam logic [7:0] ADDR_IRQ     = 8'h1c; // sticky events, write one to clear
  localparam logic [7:0] ADDR_MASK    = 8'h20; // interrupt mask
  localparam int         IRQ_W        = 2;     // bit0 done, bit1 warning
  localparam logic [7:0] M_CNT_FWD    = 8'hf9; // -7
  localparam logic [7:0] M_CNT_REV    = 8'hd9; // -39
  localparam logic [7:0] M_CRADLE_FWD = 8'hf8; // -8
  localparam logic [7:0] M_CRADLE_REV = 8'hd8; // -40
  localparam logic [7:0] M_LAST_FWD   = 8'hf7; // -9
  localparam logic [7:0] M_LAST_REV   = 8'hd7; // -41
  localparam logic [7:0] M_FRONT_FWD  = 8'hf6; // -10
  localparam logic [7:0] M_FRONT_REV  = 8'hd6; // -42
  localparam logic [7:0] M_DOGLESS_FWD = 8'hf5; // -11
  localparam logic [7:0] M_DOGLESS_REV = 8'hd5; // -43
  localparam logic [7:0] M_NEG_LIMIT  = 8'h01; // 1
  typedef enum logic [3:0] {
    HMS_IDLE    = 4'b0000,
    HMS_SEEK    = 4'b0001, // move toward dog / limit / index
    HMS_OFFSET  = 4'b0010, // travel the post-dog distance
    HMS_LEAVE   = 4'b0011, // reverse away from the stroke limit
    HMS_INDEX   = 4'b0100, // wait for first index pulse
    HMS_DONE    = 4'b0101,
    HMS_ABORT   = 4'b0110
  } hms_state_t;
  typedef struct packed {
    logic dog;
    logic index;
    logic fwd_limit;
    logic rev_limit;
  } hms_sense_t;
endpackage : hms_pkg

// ===== test/hms_motor_model.sv
// motor, encoder index, dog and stroke limit model for the homing sequencer
`timescale 1ns/1ps
module hms_motor_model #(
  parameter int DOG_LO = 20,
  parameter int DOG_HI = 60,
  parameter int FLS_AT = 100,
  parameter int RLS_AT = -40
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic move_fwd,
  input  wire logic move_rev,
  input  wire logic idx_en,
  output logic      pos_step,
  output logic      dog_input,
  output logic      index_pulse,
  output logic      forward_stroke_limit_input,
  output logic      reverse_stroke_limit_input
);
  int         pos_q;
  logic [2:0] ph_q;
  logic       go_q;
  logic       fwd_q;
  // one step pulse every eighth clock; sensors follow the position after the step is counted
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_q <= 0;
      ph_q <= 3'h0;
      go_q <= 1'b0;
      fwd_q <= 1'b0;
    end else begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h0) begin
        go_q <= move_fwd ^ move_rev;
        fwd_q <= move_fwd;
      end
      if (ph_q == 3'h3 && go_q) begin
        pos_q <= fwd_q ? pos_q + 1 : pos_q - 1;
      end
    end
  end
  // pins: dog band, index every 16 counts, stroke ends
  assign pos_step = (ph_q == 3'h1) && go_q;
  assign dog_input = (pos_q >= DOG_LO) && (pos_q <= DOG_HI);
  assign index_pulse = idx_en && (pos_q[3:0] == 4'h0);
  assign forward_stroke_limit_input = (pos_q >= FLS_AT);
  assign reverse_stroke_limit_input = (pos_q <= RLS_AT);
endmodule : hms_motor_model

// ===== test/hms_checker_assertions.sv
// port checker for the homing sequencer
`timescale 1ns/1ps
module hms_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        forward_stroke_limit_input,
  input wire logic        reverse_stroke_limit_input,
  input wire logic        move_fwd,
  input wire logic        move_rev,
  input wire logic        homing_complete,
  input wire logic        homing_incomplete_warning,
  input wire logic        irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  a_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite && haddr > 8'h20 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_single_dir: assert property (!(move_fwd && move_rev))
    else $error("both directions commanded");
  a_stop_on_done: assert property ($rose(homing_complete) |-> ##[0:3] (!move_fwd && !move_rev))
    else $error("motion after completion");
  a_done_clean: assert property ($rose(homing_complete) |-> !homing_incomplete_warning)
    else $error("completion with warning");
  a_clear_on_start: assert property ($rose(move_fwd || move_rev) |-> ##[0:3] !homing_complete)
    else $error("complete flag kept at start");
  a_fall_on_start: assert property ($fell(homing_complete) |-> ##[0:3] (move_fwd || move_rev))
    else $error("complete flag lost without start");
  a_rev_limit_stop: assert property ($rose(reverse_stroke_limit_input) && move_rev |-> ##[1:6] !move_rev)
    else $error("reverse kept at reverse stroke end");
  a_fwd_limit_stop: assert property ($rose(forward_stroke_limit_input) && move_fwd |-> ##[1:6] !move_fwd)
    else $error("forward kept at forward stroke end");
  c_done: cover property ($rose(homing_complete));
  c_warn: cover property ($rose(homing_incomplete_warning));
  c_irq: cover property ($rose(irq));
endmodule : hms_checker
bind hms_sequencer hms_checker chk_i (.*);

// ===== test/tb_top.sv
// self-checking bench for the homing method sequencer
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, idx_en = 1'b1;
  logic homing_operating_mode = 1'b1;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, dog_input, index_pulse, forward_stroke_limit_input, reverse_stroke_limit_input;
  logic pos_step, move_fwd, move_rev, homing_complete, homing_incomplete_warning, irq;
  int errors = 0, n_tests = 0, cyc = 0;
  assign hready = hreadyout;
  hms_sequencer dut (.*);
  hms_motor_model model (.*);
  // clock and hang guard
  initial begin
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one single ahb-lite transfer; read data left in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic do_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
  endtask : do_reset
  task automatic start(input logic [7:0] code, input logic sel, input int trav, input int shift);
    bus(1'b1, hms_pkg::ADDR_TRAVEL, trav);
    bus(1'b1, hms_pkg::ADDR_SHIFT, shift);
    bus(1'b1, hms_pkg::ADDR_METHOD, {{24{code[7]}}, code});
    bus(1'b1, hms_pkg::ADDR_CTRL, {30'h0, sel, 1'b1});
  endtask : start
  task automatic finish_run(input logic ok, input int home);
    int k;
    k = 0;
    while (homing_complete !== 1'b1 && homing_incomplete_warning !== 1'b1 && k < 4000) begin
      @(posedge clock);
      k++;
    end
    repeat (2) @(posedge clock);
    chk("complete", ok, homing_complete);
    chk("warning", !ok, homing_incomplete_warning);
    bus(1'b0, hms_pkg::ADDR_HOME, 32'h0);
    if (ok) chk("home", home, rd);
  endtask : finish_run
  task automatic run(input logic [7:0] code, input int trav, input int shift, input logic ok, input int home);
    do_reset();
    bus(1'b1, hms_pkg::ADDR_MASK, 32'h0);
    start(code, 1'b0, trav, shift);
    finish_run(ok, home);
    $display("run %h done", code);
  endtask : run
  task automatic t_regs;
    do_reset();
    bus(1'b0, hms_pkg::ADDR_METHOD, 32'h0);
    chk("method reset", 32'h1, rd);
    bus(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("registers done");
  endtask : t_regs
  task automatic t_dir;
    logic [7:0] codes[3];
    codes = '{hms_pkg::M_CNT_FWD, hms_pkg::M_CNT_REV, hms_pkg::M_NEG_LIMIT};
    for (int i = 0; i < 6; i++) begin
      do_reset();
      start(codes[i % 3], i / 3, 0, 0);
      repeat (8) @(posedge clock);
      chk("move_fwd", (i % 3 == 0) ^ (i / 3), move_fwd);
      chk("move_rev", (i % 3 != 0) ^ (i / 3), move_rev);
    end
    // start outside homing mode must leave the motor still
    homing_operating_mode <= 1'b0;
    do_reset();
    start(hms_pkg::M_CNT_FWD, 1'b0, 0, 0);
    repeat (8) @(posedge clock);
    chk("move outside homing mode", 1'b0, move_fwd | move_rev);
    homing_operating_mode <= 1'b1;
    $display("directions done");
  endtask : t_dir
  task automatic t_front_irq;
    run(hms_pkg::M_FRONT_FWD, 5, 3, 1'b1, 28);
    chk("irq masked", 1'b0, irq);
    bus(1'b0, hms_pkg::ADDR_IRQ, 32'h0);
    chk("irq status", 32'h1, rd);
    bus(1'b1, hms_pkg::ADDR_MASK, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq", 1'b1, irq);
    bus(1'b1, hms_pkg::ADDR_IRQ, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq cleared", 1'b0, irq);
    start(hms_pkg::M_DOGLESS_FWD, 1'b0, 5, 3);
    repeat (4) @(posedge clock);
    chk("complete at start", 1'b0, homing_complete);
    finish_run(1'b1, 35);
    $display("front end and dogless done");
  endtask : t_front_irq
  task automatic t_abort;
    idx_en <= 1'b0;
    run(hms_pkg::M_NEG_LIMIT, 0, 1, 1'b0, 0);
    bus(1'b0, hms_pkg::ADDR_IRQ, 32'h0);
    chk("irq warning status", 32'h2, rd);
    bus(1'b0, hms_pkg::ADDR_STATUS, 32'h0);
    chk("status after abort", 32'h4, rd);
    idx_en <= 1'b1;
  endtask : t_abort
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    t_regs();
    t_dir();
    t_front_irq();
    run(hms_pkg::M_CNT_FWD, 5, 3, 1'b1, 28);
    run(hms_pkg::M_CRADLE_FWD, 0, 2, 1'b1, 34);
    run(hms_pkg::M_LAST_FWD, 0, 0, 1'b1, 16);
    run(hms_pkg::M_NEG_LIMIT, 0, 1, 1'b1, -31);
    t_abort();
    report_and_stop();
  end
endmodule : tb_top
